// ### core/scd_clk_ctrl.v
`timescale 1ns/100ps
`include "scd_defs.vh"

// How it works
// - host mode takes the primary reference input, agent mode the bus-side clock
// - primary reference: engine = ref times multiplier over one plus divider
// - bus-side reference: also times one plus inverted predivide bit
// - dram clock twice system clock; halved for memory bus clock pair
// - local bus clock equals system clock; divider field sets external clock ratio
// - four units allow off, half, third; bus interface and dma off or full
// - units leave reset at full ratio; control register changes it later
// - core clock derives from the system bus clock
// - engine clock domain configured apart from system and core, same input
// - core at most 333, system 133, engine 200 MHz
module scd_clk_ctrl #(
    parameter REF_KHZ_W = 18,
    parameter NUM_LB_CLK = 3
) (
    input wire i_clk_sys,                             // ddr-rate clock, 40 MHz
    input wire i_rst,                                 // async reset, high
    input wire i_agent_mode,                          // strap: 1 bus agent, 0 bus host
    input wire i_primary_ref_input,                   // primary reference pin
    input wire i_bus_clk_in,                          // bus-side clock pin
    input wire [REF_KHZ_W-1:0] i_ref_freq_khz,        // reference frequency, kHz
    input wire [`SCD_SYSTEM_PLL_MULTIPLIER_W-1:0] i_system_pll_multiplier, // reset config
    input wire [`SCD_CORE_W-1:0] i_core_ratio,        // reset config, half steps
    input wire [`SCD_EMF_W-1:0] i_engine_pll_multiplier, // reset config
    input wire [`SCD_EDF_W-1:0] i_engine_pll_divider, // reset config
    input wire i_input_predivide_cfg,                 // reset config
    input wire [`SCD_NUM_UNITS*`SCD_RATIO_W-1:0] i_ucc_wdata, // unit ratio write data
    input wire i_ucc_we,                              // unit ratio write strobe
    input wire [`SCD_LBDIV_W-1:0] i_lbdiv_wdata,      // local bus divider write data
    input wire i_lbdiv_we,                            // local bus divider write strobe
    output wire o_cfg_valid,                          // configuration captured
    output wire o_ref_is_bus,                         // bus-side clock is reference
    output wire o_ref_clk_obs,                        // sampled selected reference
    output wire [31:0] o_sys_freq_khz,                // system bus clock
    output wire [31:0] o_core_freq_khz,               // core clock
    output wire [31:0] o_engine_freq_khz,             // engine clock
    output wire [31:0] o_ddr_freq_khz,                // dram controller clock
    output wire [31:0] o_lbc_freq_khz,                // local bus controller clock
    output wire o_core_over,                          // core above ceiling
    output wire o_sys_over,                           // system above ceiling
    output wire o_engine_over,                        // engine above ceiling
    output wire o_csb_tick,                           // system bus clock enable
    output wire o_memory_bus_clock_out_p,             // memory bus clock, true
    output wire o_memory_bus_clock_out_n,             // memory bus clock, complement
    output wire o_local_bus_sync_out,                 // local bus sync clock
    output wire [NUM_LB_CLK-1:0] o_local_bus_clock_outs, // local bus clocks
    output wire [`SCD_NUM_UNITS-1:0] o_unit_clk_en,   // per-unit clock enables
    output wire [`SCD_NUM_UNITS*`SCD_RATIO_W-1:0] o_ucc_rdata, // ratios in force
    output wire [`SCD_LBDIV_W-1:0] o_lbdiv_rdata      // local bus divider field
);

    localparam CFG_W = 1 + `SCD_SYSTEM_PLL_MULTIPLIER_W + `SCD_CORE_W + `SCD_EMF_W + `SCD_EDF_W + 1 + REF_KHZ_W;
    localparam SYS_W = REF_KHZ_W + `SCD_SYSTEM_PLL_MULTIPLIER_W;
    localparam CORE_W = SYS_W + `SCD_CORE_W;
    localparam ENG_W = REF_KHZ_W + `SCD_EMF_W + 1;

    // configuration pins, two flops then capture
    reg [CFG_W-1:0] cfg_s1_ff;
    reg [CFG_W-1:0] cfg_s2_ff;
    reg [1:0] settle_ff;
    reg cfg_valid_ff;
    reg agent_ff;
    reg [`SCD_SYSTEM_PLL_MULTIPLIER_W-1:0] system_pll_multiplier_ff;
    reg [`SCD_CORE_W-1:0] core_ff;
    reg [`SCD_EMF_W-1:0] emf_ff;
    reg [`SCD_EDF_W-1:0] edf_ff;
    reg predivide_ff;
    reg [REF_KHZ_W-1:0] ref_khz_ff;
    wire [CFG_W-1:0] cfg_pins;

    assign cfg_pins = {i_agent_mode, i_system_pll_multiplier, i_core_ratio, i_engine_pll_multiplier,
                       i_engine_pll_divider, i_input_predivide_cfg, i_ref_freq_khz};

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cfg_s1_ff <= {CFG_W{1'b0}};
            cfg_s2_ff <= {CFG_W{1'b0}};
            settle_ff <= 2'h0;
            cfg_valid_ff <= 1'b0;
            agent_ff <= 1'b0;
            system_pll_multiplier_ff <= {`SCD_SYSTEM_PLL_MULTIPLIER_W{1'b0}};
            core_ff <= {`SCD_CORE_W{1'b0}};
            emf_ff <= {`SCD_EMF_W{1'b0}};
            edf_ff <= {`SCD_EDF_W{1'b0}};
            predivide_ff <= 1'b0;
            ref_khz_ff <= {REF_KHZ_W{1'b0}};
        end else begin
            cfg_s1_ff <= cfg_pins;
            cfg_s2_ff <= cfg_s1_ff;
            if (!cfg_valid_ff) begin
                if (settle_ff == `SCD_CFG_SETTLE) begin
                    cfg_valid_ff <= 1'b1;
                    {agent_ff, system_pll_multiplier_ff, core_ff, emf_ff, edf_ff, predivide_ff, ref_khz_ff} <= cfg_s2_ff;
                end else begin
                    settle_ff <= settle_ff + 2'h1;
                end
            end
        end
    end

    // reference selection by host or agent role
    reg prim_s1_ff;
    reg prim_s2_ff;
    reg bus_s1_ff;
    reg bus_s2_ff;
    reg ref_obs_ff;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prim_s1_ff <= 1'b0;
            prim_s2_ff <= 1'b0;
            bus_s1_ff <= 1'b0;
            bus_s2_ff <= 1'b0;
            ref_obs_ff <= 1'b0;
        end else begin
            prim_s1_ff <= i_primary_ref_input;
            prim_s2_ff <= prim_s1_ff;
            bus_s1_ff <= i_bus_clk_in;
            bus_s2_ff <= bus_s1_ff;
            ref_obs_ff <= agent_ff ? bus_s2_ff : prim_s2_ff;
        end
    end

    // ratio arithmetic
    wire [SYS_W-1:0] sys_prod;
    wire [CORE_W-1:0] core_prod;
    wire [ENG_W-1:0] eng_base;
    wire [ENG_W-1:0] eng_pre;
    wire [ENG_W-1:0] eng_div;
    wire [31:0] sys_khz;
    wire [31:0] core_khz;
    wire [31:0] eng_khz;

    assign sys_prod = ref_khz_ff * system_pll_multiplier_ff;
    // core is cascaded behind the system bus clock
    assign core_prod = sys_prod * core_ff;
    // engine works from the common reference, not from the system clock
    assign eng_base = ref_khz_ff * emf_ff;
    assign eng_pre = (agent_ff && !predivide_ff) ? {eng_base[ENG_W-2:0], 1'b0} : eng_base;
    assign eng_div = (edf_ff != {`SCD_EDF_W{1'b0}}) ? {1'b0, eng_pre[ENG_W-1:1]} : eng_pre;
    assign sys_khz = {{(32-SYS_W){1'b0}}, sys_prod};
    assign core_khz = {{(33-CORE_W){1'b0}}, core_prod[CORE_W-1:1]};
    assign eng_khz = {{(32-ENG_W){1'b0}}, eng_div};

    reg [31:0] sys_khz_ff;
    reg [31:0] core_khz_ff;
    reg [31:0] eng_khz_ff;
    reg [31:0] ddr_khz_ff;
    reg core_over_ff;
    reg sys_over_ff;
    reg eng_over_ff;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sys_khz_ff <= 32'h0000_0000;
            core_khz_ff <= 32'h0000_0000;
            eng_khz_ff <= 32'h0000_0000;
            ddr_khz_ff <= 32'h0000_0000;
            core_over_ff <= 1'b0;
            sys_over_ff <= 1'b0;
            eng_over_ff <= 1'b0;
        end else begin
            sys_khz_ff <= sys_khz;
            core_khz_ff <= core_khz;
            eng_khz_ff <= eng_khz;
            ddr_khz_ff <= {sys_khz[30:0], 1'b0};
            // over only when a whole MHz above the ceiling
            core_over_ff <= cfg_valid_ff && (core_khz >= (`SCD_CORE_MAX_MHZ + 32'h0000_0001) * `SCD_KHZ_PER_MHZ);
            sys_over_ff <= cfg_valid_ff && (sys_khz >= (`SCD_SYS_MAX_MHZ + 32'h0000_0001) * `SCD_KHZ_PER_MHZ);
            eng_over_ff <= cfg_valid_ff && (eng_khz >= (`SCD_ENG_MAX_MHZ + 32'h0000_0001) * `SCD_KHZ_PER_MHZ);
        end
    end

    // system bus clock is half the dram clock; memory bus clock halves dram too
    reg csb_ph_ff;
    reg mem_p_ff;
    reg mem_n_ff;
    wire csb_tick;

    assign csb_tick = csb_ph_ff;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            csb_ph_ff <= 1'b0;
            mem_p_ff <= 1'b0;
            mem_n_ff <= 1'b1;
        end else begin
            csb_ph_ff <= ~csb_ph_ff;
            mem_p_ff <= ~mem_p_ff;
            mem_n_ff <= mem_p_ff;
        end
    end

    // local bus divider, clocked by the system bus rate
    reg [`SCD_LBDIV_W-1:0] lbdiv_ff;
    reg [`SCD_LBDIV_W-1:0] lb_div_used_ff;
    reg [`SCD_LBDIV_W-1:0] lb_cnt_ff;
    reg lb_clk_ff;
    reg [NUM_LB_CLK-1:0] lb_outs_ff;
    reg [`SCD_LBDIV_W-1:0] nxt_lb_cnt;
    reg [`SCD_LBDIV_W-1:0] nxt_lb_div;
    wire [`SCD_LBDIV_W-1:0] lb_div_req;

    assign lb_div_req = (lbdiv_ff < `SCD_LBDIV_MIN) ? `SCD_LBDIV_MIN : lbdiv_ff;

    always @* begin
        nxt_lb_cnt = lb_cnt_ff;
        nxt_lb_div = lb_div_used_ff;
        if (csb_tick) begin
            if (lb_cnt_ff >= lb_div_used_ff - 4'h1) begin
                nxt_lb_cnt = {`SCD_LBDIV_W{1'b0}};
                nxt_lb_div = lb_div_req;
            end else begin
                nxt_lb_cnt = lb_cnt_ff + 4'h1;
            end
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            lbdiv_ff <= `SCD_LBDIV_RST;
            lb_div_used_ff <= `SCD_LBDIV_RST;
            lb_cnt_ff <= {`SCD_LBDIV_W{1'b0}};
            lb_clk_ff <= 1'b0;
            lb_outs_ff <= {NUM_LB_CLK{1'b0}};
        end else begin
            if (i_lbdiv_we) begin
                lbdiv_ff <= i_lbdiv_wdata;
            end
            lb_div_used_ff <= nxt_lb_div;
            lb_cnt_ff <= nxt_lb_cnt;
            lb_clk_ff <= (nxt_lb_cnt < {1'b0, nxt_lb_div[`SCD_LBDIV_W-1:1]});
            lb_outs_ff <= {NUM_LB_CLK{nxt_lb_cnt < {1'b0, nxt_lb_div[`SCD_LBDIV_W-1:1]}}};
        end
    end

    // unit clock control register
    reg [`SCD_NUM_UNITS*`SCD_RATIO_W-1:0] ucc_ff;
    wire [`SCD_NUM_UNITS*`SCD_RATIO_W-1:0] ucc_now;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ucc_ff <= `SCD_UCC_RST;
        end else if (i_ucc_we) begin
            ucc_ff <= i_ucc_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `SCD_NUM_UNITS; gi = gi + 1) begin : g_unit
            scd_unit_clk #(
                .ALLOW_DIV((gi < `SCD_NUM_DIV_UNITS) ? 1 : 0)
            ) u_unit (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_tick(csb_tick),
                .i_ratio(ucc_ff[gi*`SCD_RATIO_W +: `SCD_RATIO_W]),
                .o_clk_en(o_unit_clk_en[gi]),
                .o_ratio(ucc_now[gi*`SCD_RATIO_W +: `SCD_RATIO_W])
            );
        end
    endgenerate

    assign o_cfg_valid = cfg_valid_ff;
    assign o_ref_is_bus = agent_ff;
    assign o_ref_clk_obs = ref_obs_ff;
    assign o_sys_freq_khz = sys_khz_ff;
    assign o_core_freq_khz = core_khz_ff;
    assign o_engine_freq_khz = eng_khz_ff;
    assign o_ddr_freq_khz = ddr_khz_ff;
    assign o_lbc_freq_khz = sys_khz_ff;
    assign o_core_over = core_over_ff;
    assign o_sys_over = sys_over_ff;
    assign o_engine_over = eng_over_ff;
    assign o_csb_tick = csb_ph_ff;
    assign o_memory_bus_clock_out_p = mem_p_ff;
    assign o_memory_bus_clock_out_n = mem_n_ff;
    assign o_local_bus_sync_out = lb_clk_ff;
    assign o_local_bus_clock_outs = lb_outs_ff;
    assign o_ucc_rdata = ucc_now;
    assign o_lbdiv_rdata = lbdiv_ff;

endmodule

// ### inc/scd_defs.vh
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH

// unit ratio codes
`define SCD_RATIO_OFF 2'h0
`define SCD_RATIO_FULL 2'h1
`define SCD_RATIO_DIV2 2'h2
`define SCD_RATIO_DIV3 2'h3
`define SCD_RATIO_W 2

// units: 0 security, 1 two-wire, 2 aux a, 3 aux b, 4 bus interface, 5 dma
`define SCD_NUM_UNITS 6
`define SCD_NUM_DIV_UNITS 4
`define SCD_UCC_RST 12'h555

// local bus divider field
`define SCD_LBDIV_W 4
`define SCD_LBDIV_RST 4'h2
`define SCD_LBDIV_MIN 4'h2

// frequency ceilings in MHz, compared in kHz
`define SCD_KHZ_PER_MHZ 32'h0000_03E8
`define SCD_CORE_MAX_MHZ 32'h0000_014D
`define SCD_SYS_MAX_MHZ 32'h0000_0085
`define SCD_ENG_MAX_MHZ 32'h0000_00C8

// reset configuration field widths
`define SCD_SYSTEM_PLL_MULTIPLIER_W 4
`define SCD_CORE_W 7
`define SCD_EMF_W 4
`define SCD_EDF_W 1

// cycles after reset release before the configuration is captured
`define SCD_CFG_SETTLE 2'h2

`endif

// ### core/scd_unit_clk.v
`timescale 1ns/100ps
`include "scd_defs.vh"

module scd_unit_clk #(
    parameter ALLOW_DIV = 1
) (
    input wire i_clk_sys,                   // ddr-rate clock
    input wire i_rst,                       // async reset, high
    input wire i_tick,                      // system bus clock enable
    input wire [`SCD_RATIO_W-1:0] i_ratio,  // requested ratio code
    output wire o_clk_en,                   // unit clock enable pulse
    output wire [`SCD_RATIO_W-1:0] o_ratio  // ratio in force
);

    reg [`SCD_RATIO_W-1:0] ratio_ff;
    reg [1:0] cnt_ff;
    reg en_ff;
    reg [`SCD_RATIO_W-1:0] nxt_ratio;
    reg [1:0] nxt_cnt;
    reg [1:0] last;
    wire legal;

    // divided codes refused on full-or-off units
    assign legal = (ALLOW_DIV != 0) || (i_ratio == `SCD_RATIO_OFF) || (i_ratio == `SCD_RATIO_FULL);

    always @* begin
        nxt_ratio = ratio_ff;
        nxt_cnt = cnt_ff;
        case (ratio_ff)
            `SCD_RATIO_DIV2: last = 2'h1;
            `SCD_RATIO_DIV3: last = 2'h2;
            default: last = 2'h0;
        endcase
        if (i_tick) begin
            if (cnt_ff >= last) begin
                nxt_cnt = 2'h0;
                // new ratio only at a period boundary
                if (legal) begin
                    nxt_ratio = i_ratio;
                end
            end else begin
                nxt_cnt = cnt_ff + 2'h1;
            end
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ratio_ff <= `SCD_RATIO_FULL;
            cnt_ff <= 2'h0;
            en_ff <= 1'b0;
        end else begin
            ratio_ff <= nxt_ratio;
            cnt_ff <= nxt_cnt;
            en_ff <= i_tick && (cnt_ff == 2'h0) && (ratio_ff != `SCD_RATIO_OFF);
        end
    end

    assign o_clk_en = en_ff;
    assign o_ratio = ratio_ff;

endmodule

// ### tb/scd_clk_ctrl_monitor.sv
`timescale 1ns/100ps
`include "scd_defs.vh"

module scd_clk_ctrl_monitor #(
    parameter REF_KHZ_W = 18,
    parameter NUM_LB_CLK = 3
) (
    input wire i_clk_sys,                              // clock
    input wire i_rst,                                  // reset
    input wire i_agent_mode,                           // strap
    input wire [`SCD_CORE_W-1:0] i_core_ratio,         // core ratio
    input wire o_cfg_valid,                            // captured
    input wire o_ref_is_bus,                           // ref select
    input wire [31:0] o_sys_freq_khz,                  // system
    input wire [31:0] o_core_freq_khz,                 // core
    input wire [31:0] o_engine_freq_khz,               // engine
    input wire [31:0] o_ddr_freq_khz,                  // dram
    input wire [31:0] o_lbc_freq_khz,                  // local bus
    input wire o_core_over,                            // flag
    input wire o_sys_over,                             // flag
    input wire o_engine_over,                          // flag
    input wire o_csb_tick,                             // tick
    input wire o_memory_bus_clock_out_p,               // mem clock
    input wire o_memory_bus_clock_out_n,               // mem clock
    input wire o_local_bus_sync_out,                   // lb sync
    input wire [NUM_LB_CLK-1:0] o_local_bus_clock_outs, // lb clocks
    input wire [`SCD_NUM_UNITS-1:0] o_unit_clk_en,     // enables
    input wire [`SCD_NUM_UNITS*`SCD_RATIO_W-1:0] o_ucc_rdata // ratios
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_tick_every_second: assert property (o_csb_tick |=> !o_csb_tick ##1 o_csb_tick)
        else $error("system tick not every second cycle");
    a_mem_clk_pair: assert property (o_cfg_valid |-> o_memory_bus_clock_out_n == !o_memory_bus_clock_out_p
        && o_memory_bus_clock_out_p != $past(o_memory_bus_clock_out_p)) else $error("memory clock pair wrong");
    a_ddr_twice_sys: assert property (o_cfg_valid && $past(o_cfg_valid) |-> o_ddr_freq_khz == o_sys_freq_khz << 1)
        else $error("dram clock not twice system");
    a_lbc_equals_sys: assert property (o_cfg_valid && $past(o_cfg_valid) |-> o_lbc_freq_khz == o_sys_freq_khz)
        else $error("local bus clock differs from system");
    a_core_from_sys: assert property (o_cfg_valid && $past(o_cfg_valid) |->
        o_core_freq_khz == (o_sys_freq_khz * {25'h0, i_core_ratio}) >> 1) else $error("core not derived from system");
    a_sys_ceiling: assert property ($past(o_cfg_valid, 2) && o_cfg_valid |->
        o_sys_over == (o_sys_freq_khz >= 32'h0002_0B70)) else $error("system ceiling flag wrong");
    a_core_ceiling: assert property ($past(o_cfg_valid, 2) && o_cfg_valid |->
        o_core_over == (o_core_freq_khz >= 32'h0005_18B0)) else $error("core ceiling flag wrong");
    a_engine_ceiling: assert property ($past(o_cfg_valid, 2) && o_cfg_valid |->
        o_engine_over == (o_engine_freq_khz >= 32'h0003_1128)) else $error("engine ceiling flag wrong");
    a_ref_select: assert property (o_cfg_valid |-> o_ref_is_bus == i_agent_mode)
        else $error("reference select differs from strap");
    a_full_only_units: assert property (!o_ucc_rdata[11] && !o_ucc_rdata[9])
        else $error("divided ratio on full-only unit");
    a_off_unit_silent: assert property (o_ucc_rdata[1:0] == `SCD_RATIO_OFF &&
        $past(o_ucc_rdata[1:0], 2) == `SCD_RATIO_OFF |-> !o_unit_clk_en[0]) else $error("gated unit pulsed");
    a_half_spacing: assert property (o_unit_clk_en[2] && o_ucc_rdata[5:4] == `SCD_RATIO_DIV2
        && $past(o_ucc_rdata[5:4]) == `SCD_RATIO_DIV2 |=> !o_unit_clk_en[2] [*3])
        else $error("half rate pulse too early");
    a_lb_same_phase: assert property (o_local_bus_clock_outs == {NUM_LB_CLK{o_local_bus_sync_out}})
        else $error("local bus clocks out of phase");
endmodule

bind scd_clk_ctrl scd_clk_ctrl_monitor #(.REF_KHZ_W(REF_KHZ_W), .NUM_LB_CLK(NUM_LB_CLK)) u_mon (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_agent_mode(i_agent_mode), .i_core_ratio(i_core_ratio),
    .o_cfg_valid(o_cfg_valid), .o_ref_is_bus(o_ref_is_bus), .o_sys_freq_khz(o_sys_freq_khz),
    .o_core_freq_khz(o_core_freq_khz), .o_engine_freq_khz(o_engine_freq_khz), .o_ddr_freq_khz(o_ddr_freq_khz),
    .o_lbc_freq_khz(o_lbc_freq_khz), .o_core_over(o_core_over), .o_sys_over(o_sys_over),
    .o_engine_over(o_engine_over), .o_csb_tick(o_csb_tick), .o_memory_bus_clock_out_p(o_memory_bus_clock_out_p),
    .o_memory_bus_clock_out_n(o_memory_bus_clock_out_n), .o_local_bus_sync_out(o_local_bus_sync_out),
    .o_local_bus_clock_outs(o_local_bus_clock_outs), .o_unit_clk_en(o_unit_clk_en), .o_ucc_rdata(o_ucc_rdata));

// ### tb/scd_far_model.sv
`timescale 1ns/100ps
`include "scd_defs.vh"

module scd_far_model (
    input wire i_clk_sys,                             // clock
    input wire i_clear,                               // restart counts
    input wire [`SCD_NUM_UNITS-1:0] i_unit_clk_en,    // unit enables
    output logic o_primary_ref_input,                 // primary pin
    output logic o_bus_clk_in,                        // bus-side pin
    output logic [4:0] o_phase,                       // pin phase
    output logic [8*`SCD_NUM_UNITS-1:0] o_pulses      // pulses per unit
);
    logic [4:0] phase_ff = 5'h00;
    integer k;

    // pins move on the falling edge, away from sampling
    always @(negedge i_clk_sys) phase_ff <= phase_ff + 5'h01;
    assign o_phase = phase_ff;
    assign o_primary_ref_input = phase_ff[3];
    assign o_bus_clk_in = phase_ff[4];

    // count each unit's enable pulses; i_clear restarts the counts
    always @(posedge i_clk_sys) begin
        for (k = 0; k < `SCD_NUM_UNITS; k++) begin
            if (i_clear) o_pulses[8*k +: 8] <= 8'h00;
            else if (i_unit_clk_en[k]) o_pulses[8*k +: 8] <= o_pulses[8*k +: 8] + 8'h01;
        end
    end
endmodule

// ### tb/tb_scd_clk_ctrl.sv
`timescale 1ns/100ps
`include "scd_defs.vh"

module tb_scd_clk_ctrl;
    logic clk, rst, agent, pred, ucc_we, lb_we, clear, edf, pri, bus;
    logic [17:0] ref_khz;
    logic [3:0] system_pll_multiplier, emf, lb_wd, lb_rd;
    logic [6:0] cratio;
    logic [11:0] ucc_wd, ucc_rd;
    logic cfg_valid, ref_is_bus, ref_obs, core_ov, sys_ov, eng_ov, tick, mp, mn, lb_sync;
    logic [31:0] sys_f, core_f, eng_f, ddr_f, lbc_f;
    logic [2:0] lclk;
    logic [5:0] uen;
    logic [4:0] phase;
    logic [47:0] pulses;
    integer miscompares, checks_done;

    scd_clk_ctrl i_dut (.i_clk_sys(clk), .i_rst(rst), .i_agent_mode(agent), .i_primary_ref_input(pri),
        .i_bus_clk_in(bus), .i_ref_freq_khz(ref_khz), .i_system_pll_multiplier(system_pll_multiplier), .i_core_ratio(cratio),
        .i_engine_pll_multiplier(emf), .i_engine_pll_divider(edf), .i_input_predivide_cfg(pred),
        .i_ucc_wdata(ucc_wd), .i_ucc_we(ucc_we), .i_lbdiv_wdata(lb_wd), .i_lbdiv_we(lb_we),
        .o_cfg_valid(cfg_valid), .o_ref_is_bus(ref_is_bus), .o_ref_clk_obs(ref_obs), .o_sys_freq_khz(sys_f),
        .o_core_freq_khz(core_f), .o_engine_freq_khz(eng_f), .o_ddr_freq_khz(ddr_f), .o_lbc_freq_khz(lbc_f),
        .o_core_over(core_ov), .o_sys_over(sys_ov), .o_engine_over(eng_ov), .o_csb_tick(tick),
        .o_memory_bus_clock_out_p(mp), .o_memory_bus_clock_out_n(mn), .o_local_bus_sync_out(lb_sync),
        .o_local_bus_clock_outs(lclk), .o_unit_clk_en(uen), .o_ucc_rdata(ucc_rd), .o_lbdiv_rdata(lb_rd));
    scd_far_model u_far (.i_clk_sys(clk), .i_clear(clear), .i_unit_clk_en(uen), .o_primary_ref_input(pri),
        .o_bus_clk_in(bus), .o_phase(phase), .o_pulses(pulses));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict;
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        miscompares++;
        $display("Error %s expected done seen timeout", what);
        print_verdict;
    endtask

    task automatic t_config(input logic a, p, input logic [17:0] r, input logic [3:0] sm,
                            input logic [6:0] cr, input logic [3:0] em, input logic e);
        logic [31:0] sys, eng;
        integer n;
        @(negedge clk);
        rst = 1'b1; agent = a; pred = p; ref_khz = r; system_pll_multiplier = sm; cratio = cr; emf = em; edf = e;
        repeat (6) @(negedge clk);
        check("ratios in reset", {20'h0, ucc_rd}, 32'h0000_0555);
        rst = 1'b0;
        for (n = 0; n < 10 && cfg_valid !== 1'b1; n++) @(negedge clk);
        if (cfg_valid !== 1'b1) timeout("config capture");
        repeat (2) @(negedge clk);
        sys = r * sm;
        eng = r * em * ((a && !p) ? 2 : 1) / (e + 1);
        check("system clock", sys_f, sys);
        check("core clock", core_f, sys * cr / 2);
        check("engine clock", eng_f, eng);
        check("dram clock", ddr_f, 2 * sys);
        check("local bus clock", lbc_f, sys);
        check("ceiling flags", {29'h0, core_ov, sys_ov, eng_ov},
              {29'h0, (sys * cr / 2) >= 32'h0005_18B0, sys >= 32'h0002_0B70, eng >= 32'h0003_1128});
        check("reference is bus", {31'h0, ref_is_bus}, {31'h0, a});
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            #1;
            if ((a ? phase[3:0] : {1'b0, phase[2:0]}) >= 4'h5)
                check("selected reference", {31'h0, ref_obs}, {31'h0, a ? bus : pri});
        end
    endtask

    task automatic t_ratio(input logic [11:0] w1, w2, exp);
        integer n, k;
        logic [7:0] want;
        @(negedge clk);
        ucc_wd = w1;
        ucc_we = 1'b1;
        @(negedge clk);
        ucc_wd = w2;
        @(negedge clk);
        ucc_we = 1'b0;
        for (n = 0; n < 20 && ucc_rd !== exp; n++) @(negedge clk);
        if (ucc_rd !== exp) timeout("ratio update");
        check("ratios in force", {20'h0, ucc_rd}, {20'h0, exp});
        repeat (12) @(negedge clk);
        clear = 1'b1;
        @(negedge clk);
        clear = 1'b0;
        repeat (120) @(negedge clk);
        for (k = 0; k < 6; k++) begin
            case (exp[2*k +: 2])
                `SCD_RATIO_OFF: want = 8'h00;
                `SCD_RATIO_FULL: want = 8'h3C;
                `SCD_RATIO_DIV2: want = 8'h1E;
                default: want = 8'h14;
            endcase
            check("unit pulse count", {24'h0, pulses[8*k +: 8]}, {24'h0, want});
        end
    endtask

    task automatic t_lbdiv(input logic [3:0] f);
        integer n, hi, lo;
        logic [3:0] nd;
        nd = (f < 4'h2) ? 4'h2 : f;
        @(negedge clk);
        lb_wd = f;
        lb_we = 1'b1;
        @(negedge clk);
        lb_we = 1'b0;
        check("lb divider field", {28'h0, lb_rd}, {28'h0, f});
        repeat (64) @(negedge clk);
        for (n = 0; n < 64 && lb_sync !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 64 && lb_sync !== 1'b1; n++) @(negedge clk);
        if (lb_sync !== 1'b1) timeout("lb clock edge");
        hi = 0;
        lo = 0;
        while (lb_sync === 1'b1 && hi < 64) begin
            @(negedge clk);
            hi++;
        end
        while (lb_sync === 1'b0 && lo < 64) begin
            @(negedge clk);
            lo++;
        end
        check("lb clock high", hi, 2 * (nd / 2));
        check("lb clock period", hi + lo, 2 * nd);
    endtask

    initial begin
        rst = 1'b1; agent = 1'b0; pred = 1'b0; ref_khz = 18'h0_0000; system_pll_multiplier = 4'h0; cratio = 7'h00;
        emf = 4'h0; edf = 1'b0; ucc_wd = 12'h000; ucc_we = 1'b0; lb_wd = 4'h0; lb_we = 1'b0; clear = 1'b0;
        miscompares = 0;
        checks_done = 0;
        t_config(1'b0, 1'b0, 18'h0_8232, 4'h4, 7'h04, 4'h6, 1'b0);
        t_ratio(12'hEE4, 12'hEE4, 12'h5E4);
        t_ratio(12'h500, 12'h3FF, 12'h1FF);
        t_ratio(12'h41B, 12'h41B, 12'h41B);
        t_lbdiv(4'h3);
        t_lbdiv(4'h5);
        t_lbdiv(4'h0);
        t_lbdiv(4'h2);
        t_config(1'b1, 1'b0, 18'h1_046E, 4'h4, 7'h05, 4'h6, 1'b1);
        t_config(1'b1, 1'b1, 18'h0_61A8, 4'h5, 7'h05, 4'h8, 1'b1);
        t_ratio(12'hEE4, 12'hEE4, 12'h5E4);
        print_verdict;
    end
endmodule
